// ==== dv/sarrp_host_model.sv ====
`timescale 1ns/1ns
module sarrp_host_model (
  // link pins
  input  wire logic   bclk_i,
  input  wire logic   oe_i,
  input  wire logic   data_i,
  input  wire logic   sync_i,
  // frame control and capture
  input  wire logic   go_i,
  output logic        hclk_o,
  output int          pulses_o,
  output int          bad_o,
  output logic [15:0] word_o,
  output logic [16:0] ext_o,
  output logic [1:0]  sync_o
);
  logic bit_q;
  logic seen;
  initial begin
    hclk_o   = 1'b0;
    pulses_o = 0;
    bad_o    = 0;
    seen     = 1'b0;
  end
  // internal frame: take bit on rise, recheck on the matching fall
  always @(posedge bclk_i) if (oe_i === 1'b1) begin
    bit_q = data_i;
    seen = 1'b1;
    word_o = {word_o[14:0], data_i};
    pulses_o++;
  end
  always @(negedge bclk_i) if (seen === 1'b1 && oe_i === 1'b1) begin
    if (data_i !== bit_q) bad_o++;
    seen = 1'b0;
  end
  // external frame: clock stands low outside it
  always @(posedge go_i) begin
    for (int k = 1; k <= 18; k++) begin
      #80;
      if (k >= 2) ext_o = {ext_o[15:0], data_i};
      if (k == 2) sync_o[1] = sync_i;
      if (k == 3) sync_o[0] = sync_i;
      hclk_o = 1'b1;
      #80;
      hclk_o = 1'b0;
    end
  end
endmodule // sarrp_host_model

// ==== dv/sarrp_properties.sv ====
`timescale 1ns/1ns
module sarrp_properties #(
  parameter int CONV_CYC      = 400,
  parameter int BCLK_HALF_CYC = 11
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // watched pins
  input wire logic clock_source_select_i,
  input wire logic power_down_request_i,
  input wire logic sample_hold_o,
  input wire logic busy_o,
  input wire logic serial_bit_clock_o,
  input wire logic serial_bit_clock_oe_o,
  input wire logic serial_data_o,
  input wire logic sync_o
);
  logic [2:0]  up;
  logic [3:0]  sel_h;
  logic [3:0]  pd_h;
  logic [15:0] lo_n;
  logic [15:0] hi_n;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  //////////////////////////////
  // pin history, settles after reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up    <= 3'h0;
      sel_h <= 4'h0;
      pd_h  <= 4'h0;
    end else begin
      up    <= (up == 3'h7) ? up : up + 3'h1;
      sel_h <= {sel_h[2:0], clock_source_select_i};
      pd_h  <= {pd_h[2:0], power_down_request_i};
    end
  end
  // widths of busy low and bit clock high
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_n <= 16'h0000;
      hi_n <= 16'h0000;
    end else begin
      lo_n <= busy_o ? 16'h0000 : lo_n + 16'h0001;
      hi_n <= serial_bit_clock_o ? hi_n + 16'h0001 : 16'h0000;
    end
  end
  //////////////////////////////
  busy_span_a: assert property ($rose(busy_o) |-> lo_n >= CONV_CYC)
    else $error("busy low too short");
  hold_start_a: assert property ($fell(busy_o) |-> sample_hold_o)
    else $error("no hold at start");
  hold_busy_a: assert property (sample_hold_o |-> !busy_o)
    else $error("hold while idle");
  pd_block_a: assert property ((&pd_h && $past(busy_o)) |-> busy_o)
    else $error("convert in power-down");
  oe_mode_a: assert property (
    (up == 3'h7 && sel_h == {4{clock_source_select_i}})
    |-> serial_bit_clock_oe_o == !clock_source_select_i)
    else $error("bit clock pin direction");
  bclk_high_a: assert property (
    $fell(serial_bit_clock_o) |-> hi_n == BCLK_HALF_CYC)
    else $error("bit clock high width");
  data_hold_a: assert property (
    (serial_bit_clock_oe_o && serial_bit_clock_o
     && $past(serial_bit_clock_o)) |-> $stable(serial_data_o))
    else $error("data moved in high pulse");
  sync_width_a: assert property (
    $rose(sync_o) |-> sync_o [*7] ##[1:2] !sync_o)
    else $error("sync width");
  sync_ext_a: assert property (sync_o |-> clock_source_select_i)
    else $error("sync in internal mode");
endmodule // sarrp_properties

bind sarrp_top sarrp_properties #(
  .CONV_CYC(CONV_CYC), .BCLK_HALF_CYC(BCLK_HALF_CYC)
) props (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .clock_source_select_i(clock_source_select_i),
  .power_down_request_i(power_down_request_i),
  .sample_hold_o(sample_hold_o), .busy_o(busy_o),
  .serial_bit_clock_o(serial_bit_clock_o),
  .serial_bit_clock_oe_o(serial_bit_clock_oe_o),
  .serial_data_o(serial_data_o), .sync_o(sync_o)
);

// ==== dv/sarrp_tb_top.sv ====
`timescale 1ns/1ns
module sarrp_tb_top;
  logic        clk = 1'b0;
  logic        rst_n, cs_n, rc, ocs, csel, pd, tag, go;
  logic        sh, lp, busy, bco, boe, sd, syn, hclk, bclk;
  logic [15:0] res, word;
  logic [16:0] ext;
  logic [1:0]  sy;
  logic [31:0] seed = 32'h0000432F;
  int          pulses, bad, err_count, check_count;
  always #10 clk = ~clk;
  assign bclk = boe ? bco : hclk;
  sarrp_top #(.CONV_CYC(200)) uut (
    .sys_clk_i(clk), .reset_n_i(rst_n), .chip_select_n_i(cs_n),
    .read_convert_i(rc), .output_code_select_i(ocs),
    .clock_source_select_i(csel), .power_down_request_i(pd),
    .tag_i(tag), .conv_result_i(res), .sample_hold_o(sh),
    .low_power_o(lp), .busy_o(busy), .serial_bit_clock_i(bclk),
    .serial_bit_clock_o(bco), .serial_bit_clock_oe_o(boe),
    .serial_data_o(sd), .sync_o(syn));
  sarrp_host_model host (
    .bclk_i(bclk), .oe_i(boe), .data_i(sd), .sync_i(syn), .go_i(go),
    .hclk_o(hclk), .pulses_o(pulses), .bad_o(bad), .word_o(word),
    .ext_o(ext), .sync_o(sy));
  //////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] code(input logic [15:0] v, input logic b);
    return b ? v : {~v[15], v[14:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // start by read/convert or by select, then wait for the frame
  task automatic conv(input bit via_cs);
    int   base;
    logic t0;
    logic fell;
    base = pulses;
    fell = 1'b0;
    if (via_cs) begin
      cs_n = 1'b1;
      cyc(3);
      rc = 1'b0;
      cyc(6);
      chk(busy, 1);
      cs_n = 1'b0;
    end else rc = 1'b0;
    cyc(4);
    rc = 1'b1;
    t0 = tag;
    if (csel) go = 1'b1;
    else tag = ~tag;
    for (int w = 0; w < 1500; w++) begin
      if (busy === 1'b0) fell = 1'b1;
      if (fell && busy === 1'b1 && (csel || pulses == base + 16)) break;
      cyc(1);
    end
    chk(fell, 1);
    cyc(30);
    go = 1'b0;
    if (!csel) begin
      chk(pulses - base, 16);
      chk(sd, t0);
    end
  endtask
  //////////////////////////////
  initial begin
    logic [31:0] r;
    logic [15:0] prev;
    {cs_n, rc, ocs, csel, pd, tag, go, rst_n} = 8'hE0;
    res = 16'h0000;
    cyc(20);
    rst_n = 1'b1;
    cyc(5);
    cs_n = 1'b0;
    cyc(3);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      res = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : r[15:0];
      ocs = i[0];
      tag = r[16];
      conv(i[1]);
      pd = 1'b1;
      cyc(6);
      chk(lp, 1);
      rc = 1'b0;
      cyc(20);
      chk(busy, 1);
      rc = 1'b1;
      pd = 1'b0;
      cyc(6);
      conv(i[1]);
      chk(word, code(res, ocs));
      chk(boe, 1);
      chk(bco, 0);
      chk(bad, 0);
      $display("internal test %0d done", i);
    end
    csel = 1'b1;
    cyc(6);
    chk(boe, 0);
    prev = res;
    r = rnd();
    res = r[15:0];
    conv(0);
    chk(ext, {code(prev, ocs), tag});
    chk(sy, 2'b10);
    cs_n = 1'b1;
    cyc(4);
    cs_n = 1'b0;
    cyc(4);
    go = 1'b1;
    cyc(170);
    go = 1'b0;
    chk(ext, {code(res, ocs), tag});
    chk(sy, 2'b10);
    $display("external test done");
    end_of_test();
  end
  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end
endmodule // sarrp_tb_top

// ==== include/sarrp_consts.svh ====
`ifndef SARRP_CONSTS_SVH
`define SARRP_CONSTS_SVH

// system clock period
`define SARRP_SYS_CLK_NS      20
// result width and bit clock pulses per frame
`define SARRP_RESULT_BITS     16
// conversion time, longest
`define SARRP_CONV_NS         8000
`define SARRP_CONV_CYC        (`SARRP_CONV_NS / `SARRP_SYS_CLK_NS)
// internal bit clock period
`define SARRP_BCLK_NS         440
`define SARRP_BCLK_HALF_CYC   ((`SARRP_BCLK_NS / 2) / `SARRP_SYS_CLK_NS)
// convert command to first internal bit clock
`define SARRP_BCLK_DLY_NS     450
`define SARRP_BCLK_DLY_CYC    (`SARRP_BCLK_DLY_NS / `SARRP_SYS_CLK_NS)
// result buffer depth
`define SARRP_BUF_DEPTH       2
// synchroniser stages
`define SARRP_SYNC_STAGES     2
// reset value of held result
`define SARRP_RESULT_RST      16'h0000

`endif

// ==== include/sarrp_pkg.sv ====
package sarrp_pkg;

  // conversion sequencer
  typedef enum logic [2:0] {
    CONV_IDLE  = 3'b001,
    CONV_RUN   = 3'b010,
    CONV_STORE = 3'b100
  } sarrp_conv_state_t;

  // internal bit clock generator
  typedef enum logic [2:0] {
    ICLK_IDLE  = 3'b001,
    ICLK_DELAY = 3'b010,
    ICLK_SEND  = 3'b100
  } sarrp_iclk_state_t;

endpackage

// ==== rtl/sarrp_buf.sv ====
`timescale 1ns/1ns
module sarrp_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule // sarrp_buf

// ==== rtl/sarrp_sync.sv ====
`timescale 1ns/1ns
module sarrp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage1[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          sync_o[g] <= stage1[g];
        end
      end
    end
  endgenerate

endmodule // sarrp_sync

// ==== rtl/sarrp_top.sv ====
// How it works
// - output_code_select high sends straight binary, low sends two's complement.
// - with clock_source_select high, data shifts on the host's serial_bit_clock.
// - with clock_source_select low, a convert sends the last result with 16 own pulses.
// - the bit clock pin is driven only when internal clocking is selected.
// - after its burst the internal bit clock stays low.
// - in external mode a rising convert edge or falling select edge gives a sync pulse.
// - in external mode the tag input follows the result, 16 bit clocks late.
// - internal mode data holds across both edges of its bit clock pulse.
// - between internal frames data shows the tag level caught at convert.
// - a falling convert edge with chip select low holds the sample and converts.
// - chip select and read/convert are ORed into the active-low convert term.
// - busy is low from convert until the result is written into the result buffer.
// - power-down blocks conversions and shows the low-power state.
// - power-down keeps the held result readable by external clocking; internal frames need a convert, which it blocks.
`timescale 1ns/1ns
`include "sarrp_consts.svh"
module sarrp_top #(
  parameter int RESULT_BITS   = `SARRP_RESULT_BITS,
  parameter int CONV_CYC      = `SARRP_CONV_CYC,
  parameter int BCLK_HALF_CYC = `SARRP_BCLK_HALF_CYC,
  parameter int BCLK_DLY_CYC  = `SARRP_BCLK_DLY_CYC,
  parameter int BUF_DEPTH     = `SARRP_BUF_DEPTH
) (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  // host control pins
  input  wire logic                   chip_select_n_i,
  input  wire logic                   read_convert_i,
  input  wire logic                   output_code_select_i,
  input  wire logic                   clock_source_select_i,
  input  wire logic                   power_down_request_i,
  input  wire logic                   tag_i,
  // converter core
  input  wire logic [RESULT_BITS-1:0] conv_result_i,
  output logic                        sample_hold_o,
  output logic                        low_power_o,
  output logic                        busy_o,
  // serial link
  input  wire logic                   serial_bit_clock_i,
  output logic                        serial_bit_clock_o,
  output logic                        serial_bit_clock_oe_o,
  output logic                        serial_data_o,
  output logic                        sync_o
);

  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int PW = $clog2(2 * BCLK_HALF_CYC + BCLK_DLY_CYC + 1);
  localparam int BW = $clog2(RESULT_BITS + 1);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edges

  logic [6:0] pins_sync;
  logic       cs_n;
  logic       rc;
  logic       code_sel;
  logic       clk_sel;
  logic       pd;
  logic       tag;
  logic       hclk;
  logic       cs_n_d;
  logic       rc_d;
  logic       hclk_d;
  logic       conv_low;
  logic       conv_low_d;

  sarrp_sync #(
    .WIDTH (7)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({serial_bit_clock_i, tag_i, power_down_request_i,
                 clock_source_select_i, output_code_select_i,
                 read_convert_i, chip_select_n_i}),
    .sync_o    (pins_sync)
  );

  assign cs_n     = pins_sync[0];
  assign rc       = pins_sync[1];
  assign code_sel = pins_sync[2];
  assign clk_sel  = pins_sync[3];
  assign pd       = pins_sync[4];
  assign tag      = pins_sync[5];
  assign hclk     = pins_sync[6];
  assign conv_low = cs_n | rc;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_n_d     <= 1'b1;
      rc_d       <= 1'b1;
      hclk_d     <= 1'b0;
      conv_low_d <= 1'b0; // synchroniser resets low: no false convert edge
    end else begin
      cs_n_d     <= cs_n;
      rc_d       <= rc;
      hclk_d     <= hclk;
      conv_low_d <= conv_low;
    end
  end

  logic convert_edge;
  logic hclk_rise;
  logic ext_arm;
  logic ext_go;

  assign convert_edge = conv_low_d && !conv_low;
  assign hclk_rise    = hclk && !hclk_d;
  assign ext_arm      = clk_sel && ((rc && !rc_d && !cs_n) ||
                                    (!cs_n && cs_n_d && rc));
  assign ext_go       = clk_sel && !cs_n && rc;

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  sarrp_pkg::sarrp_conv_state_t conv_state;
  logic [CW-1:0]                conv_cnt;
  logic                         conv_start;
  logic                         buf_in_ready;
  logic                         buf_in_valid;

  assign conv_start   = convert_edge && !pd &&
                        (conv_state == sarrp_pkg::CONV_IDLE);
  assign buf_in_valid = (conv_state == sarrp_pkg::CONV_STORE);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_state <= sarrp_pkg::CONV_IDLE;
      conv_cnt   <= '0;
    end else begin
      case (conv_state)
        sarrp_pkg::CONV_IDLE: begin
          if (conv_start) begin
            conv_state <= sarrp_pkg::CONV_RUN;
            conv_cnt   <= CW'(CONV_CYC - 1);
          end
        end
        sarrp_pkg::CONV_RUN: begin
          if (conv_cnt == '0) begin
            conv_state <= sarrp_pkg::CONV_STORE;
          end else begin
            conv_cnt <= conv_cnt - 1'b1;
          end
        end
        sarrp_pkg::CONV_STORE: begin
          if (buf_in_ready) begin // busy stays low until latched
            conv_state <= sarrp_pkg::CONV_IDLE;
          end
        end
        default: begin
          conv_state <= sarrp_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  assign busy_o        = (conv_state == sarrp_pkg::CONV_IDLE);
  assign sample_hold_o = (conv_state != sarrp_pkg::CONV_IDLE);
  assign low_power_o   = pd;

  ////////////////////////////////////////////////////////////////////////
  // result buffer and held result

  logic                   buf_out_valid;
  logic                   buf_out_ready;
  logic [RESULT_BITS-1:0] buf_out_data;
  logic [RESULT_BITS-1:0] held_result;
  logic [RESULT_BITS-1:0] coded_result;
  logic                   iclk_busy;

  sarrp_buf #(
    .WIDTH (RESULT_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (conv_result_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );

  // no update while an internal frame is sending
  assign buf_out_ready = !iclk_busy;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held_result <= `SARRP_RESULT_RST;
    end else if (buf_out_valid && buf_out_ready) begin
      held_result <= buf_out_data;
    end
  end

  assign coded_result = code_sel ? held_result :
      {~held_result[RESULT_BITS-1], held_result[RESULT_BITS-2:0]};

  ////////////////////////////////////////////////////////////////////////
  // internal bit clock generator

  sarrp_pkg::sarrp_iclk_state_t iclk_state;
  logic [PW-1:0]                iclk_cnt;
  logic [BW-1:0]                iclk_bits;
  logic                         iclk_start;
  logic                         iclk_shift;

  assign iclk_start = conv_start && !clk_sel;
  assign iclk_busy  = (iclk_state != sarrp_pkg::ICLK_IDLE);
  // shift mid-low so each bit spans a whole high pulse
  assign iclk_shift = (iclk_state == sarrp_pkg::ICLK_SEND) &&
                      (iclk_cnt == PW'(BCLK_HALF_CYC / 2));

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iclk_state <= sarrp_pkg::ICLK_IDLE;
      iclk_cnt   <= '0;
      iclk_bits  <= '0;
    end else begin
      case (iclk_state)
        sarrp_pkg::ICLK_IDLE: begin
          if (iclk_start) begin
            iclk_state <= sarrp_pkg::ICLK_DELAY;
            iclk_cnt   <= PW'(BCLK_DLY_CYC - BCLK_HALF_CYC - 1);
          end
        end
        sarrp_pkg::ICLK_DELAY: begin
          if (iclk_cnt == '0) begin
            iclk_state <= sarrp_pkg::ICLK_SEND;
            iclk_bits  <= BW'(RESULT_BITS);
          end else begin
            iclk_cnt <= iclk_cnt - 1'b1;
          end
        end
        sarrp_pkg::ICLK_SEND: begin
          if (iclk_cnt == PW'(2 * BCLK_HALF_CYC - 1)) begin
            iclk_cnt  <= '0;
            iclk_bits <= iclk_bits - 1'b1;
            if (iclk_bits == BW'(1)) begin
              iclk_state <= sarrp_pkg::ICLK_IDLE;
            end
          end else begin
            iclk_cnt <= iclk_cnt + 1'b1;
          end
        end
        default: begin
          iclk_state <= sarrp_pkg::ICLK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_bit_clock_o <= 1'b0;
    end else begin
      serial_bit_clock_o <= (iclk_state == sarrp_pkg::ICLK_SEND) &&
          (iclk_cnt >= PW'(BCLK_HALF_CYC - 1)) &&
          (iclk_cnt != PW'(2 * BCLK_HALF_CYC - 1));
    end
  end

  assign serial_bit_clock_oe_o = !clk_sel;

  ////////////////////////////////////////////////////////////////////////
  // sync pulse, external mode

  logic sync_pend;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_pend <= 1'b0;
      sync_o    <= 1'b0;
    end else if (!clk_sel) begin
      sync_pend <= 1'b0;
      sync_o    <= 1'b0;
    end else if (ext_arm) begin
      sync_pend <= 1'b1;
    end else if (hclk_rise) begin
      sync_o    <= sync_pend;
      sync_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output shift register and data pin

  logic [RESULT_BITS-1:0] shreg;
  logic                   idle_tag;
  logic                   next_data;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_tag <= 1'b0;
    end else if (iclk_start) begin
      idle_tag <= tag;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shreg <= '0;
    end else if (iclk_start || ext_arm) begin
      shreg <= coded_result;
    end else if (iclk_shift && iclk_bits != BW'(RESULT_BITS)) begin
      shreg <= {shreg[RESULT_BITS-2:0], 1'b0};
    end else if (hclk_rise && ext_go && !sync_pend && !ext_arm) begin
      shreg <= {shreg[RESULT_BITS-2:0], tag};
    end
  end

  always_comb begin
    next_data = shreg[RESULT_BITS-1];
    if (!clk_sel && iclk_state != sarrp_pkg::ICLK_SEND) begin
      next_data = idle_tag;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_data_o <= 1'b0;
    end else begin
      serial_data_o <= next_data;
    end
  end

endmodule // sarrp_top
